// ---- dmtd_core.sv ----
// Data memory transfer decoder and sequencer with its data memory
`timescale 1ns/100ps
`default_nettype none
`include "dmtd_consts.svh"

module dmtd_core (
  // Clock and synchronous active-low reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Instruction handshake
  input wire logic instrValid,
  output logic instrReady,
  input wire logic [15:0] instrWord,
  output logic instrDone,
  output logic instrUnknown,
  // Addressing context, read live while busy
  input wire logic [`DMTD_BANK_W-1:0] bankSel,
  input wire logic pointerEnableFlag,
  input wire logic [`DMTD_BANK_W+`DMTD_ROW_W-1:0] rowPointer,
  input wire logic indexEnableFlag,
  input wire logic [`DMTD_ADDR_W-1:0] indexRegister,
  input wire logic [`DMTD_BANK_W+`DMTD_ROW_W-1:0] registerPointer,
  // Memory observation
  input wire logic [`DMTD_ADDR_W-1:0] dbgAddr,
  output logic [3:0] dbgData
);
  // ---------------------------------------------------------------
  // Storage and state
  // ---------------------------------------------------------------
  // Data memory; not reset, so a nibble reads unknown until written
  logic [3:0] dataMem [0:`DMTD_MEM_WORDS-1];

  // All sequencer state in one packed struct and its next value
  dmtd_pkg::dmtd_regs_t s_reg;
  dmtd_pkg::dmtd_regs_t s_next;

  // Opcodes of the held and of the offered word
  logic [4:0] opcNow;
  logic [4:0] opcIn;
  logic known;

  // One flag per held opcode that steers an address or, for isStore, the next state
  logic isStore;
  logic isLoad;
  logic isToInd;
  logic isFromInd;

  // Memory read and write ports
  logic [`DMTD_ADDR_W-1:0] rdAddr;
  logic [3:0] rdData;
  logic [`DMTD_ADDR_W-1:0] wrAddr;
  logic wrEn;

  // Bundle to the address former
  dmtd_addr_if af();

  // ---------------------------------------------------------------
  // Address former
  // ---------------------------------------------------------------
  // Bank, flags and pointers are read live, so the source must hold
  // them steady from the accept edge until the done cycle; the
  // column read from the general register is kept in its own field
  assign af.word = s_reg.word;
  assign af.bank = bankSel;
  assign af.idxEn = indexEnableFlag;
  assign af.idx = indexRegister;
  assign af.ptrEn = pointerEnableFlag;
  assign af.rowPtr = rowPointer;
  assign af.regPtr = registerPointer;
  assign af.grVal = s_reg.col;

  dmtd_addr_form uForm (
    .af(af.former)
  );

  // ---------------------------------------------------------------
  // Opcode fields
  // ---------------------------------------------------------------
  // Opcode of the held and of the offered instruction
  assign opcNow = s_reg.word[`DMTD_OPC_MSB:`DMTD_OPC_LSB];
  assign opcIn = instrWord[`DMTD_OPC_MSB:`DMTD_OPC_LSB];

  // ---------------------------------------------------------------
  // Held instruction decode
  // ---------------------------------------------------------------
  // Flags that steer the read and write addresses and, by isStore, the next state
  assign isStore = (opcNow == `DMTD_OPC_STORE);
  assign isToInd = (opcNow == `DMTD_OPC_MOVE_TO_IND);
  assign isFromInd = (opcNow == `DMTD_OPC_MOVE_FROM_IND);
  assign isLoad = (opcNow == `DMTD_OPC_LOAD);

  // ---------------------------------------------------------------
  // Offered instruction decode
  // ---------------------------------------------------------------
  // Recognised opcodes
  always_comb begin
    unique case (opcIn)
      `DMTD_OPC_STORE,
      `DMTD_OPC_MOVE_TO_IND,
      `DMTD_OPC_MOVE_FROM_IND,
      `DMTD_OPC_MOVE_IMM,
      `DMTD_OPC_LOAD: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Memory read selection
  // ---------------------------------------------------------------
  always_comb begin
    rdAddr = af.dirAddr;
    if (s_reg.st == dmtd_pkg::ST_GETREG) begin
      rdAddr = af.regAddr;
    end else if (s_reg.st == dmtd_pkg::ST_GETSRC && isFromInd) begin
      rdAddr = af.indAddr;
    end
  end
  assign rdData = dataMem[rdAddr];

  // Write target chosen by the opcode
  always_comb begin
    wrAddr = af.dirAddr;
    if (isLoad) begin
      wrAddr = af.regAddr;
    end else if (isToInd) begin
      wrAddr = af.indAddr;
    end
  end
  assign wrEn = (s_reg.st == dmtd_pkg::ST_STORE);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Cycle walk after the accept edge, one state per cycle:
  //   immediate move: store
  //   store:          get register, store
  //   load:           get source, store
  //   indirect moves: get register, get source, store
  // Get register reads the general register row; its nibble is the
  // data of a store and the column of both indirect moves.
  // Get source reads the direct operand, or the indirect address for
  // the move from indirect. Store writes the held data nibble and
  // pulses done; the next instruction is taken one cycle later.
  // Offers while busy are ignored because ready is low.
  always_comb begin
    s_next = s_reg;
    s_next.dbgData = dataMem[dbgAddr];
    unique case (s_reg.st)
      dmtd_pkg::ST_IDLE: begin
        if (instrValid && known) begin
          s_next.word = instrWord;
          unique case (opcIn)
            `DMTD_OPC_MOVE_IMM: begin
              s_next.data = instrWord[`DMTD_LOW_MSB:`DMTD_LOW_LSB];
              s_next.st = dmtd_pkg::ST_STORE;
            end
            `DMTD_OPC_LOAD: s_next.st = dmtd_pkg::ST_GETSRC;
            default: s_next.st = dmtd_pkg::ST_GETREG;
          endcase
        end
      end
      dmtd_pkg::ST_GETREG: begin
        // Register value: data to store, or the indirect column
        s_next.data = rdData;
        s_next.col = rdData;
        if (isStore) begin
          s_next.st = dmtd_pkg::ST_STORE;
        end else begin
          s_next.st = dmtd_pkg::ST_GETSRC;
        end
      end
      dmtd_pkg::ST_GETSRC: begin
        // Source nibble; the column stays in its own field
        s_next.data = rdData;
        s_next.st = dmtd_pkg::ST_STORE;
      end
      dmtd_pkg::ST_STORE: s_next.st = dmtd_pkg::ST_IDLE;
      default: s_next.st = dmtd_pkg::ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers and memory write
  // ---------------------------------------------------------------
  // State register; synchronous reset returns to idle with ready high
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_reg.st <= dmtd_pkg::ST_IDLE;
      s_reg.word <= `DMTD_RST_WORD;
      s_reg.data <= `DMTD_RST_NIB;
      s_reg.col <= `DMTD_RST_NIB;
      s_reg.dbgData <= `DMTD_RST_NIB;
    end else begin
      s_reg <= s_next;
    end
  end

  // Data memory write; only the target nibble changes
  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      dataMem[wrAddr] <= s_reg.data;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Ready while idle; done marks the cycle of the memory write
  assign instrReady = (s_reg.st == dmtd_pkg::ST_IDLE);
  assign instrDone = wrEn;

  // Unsupported opcode: refused in the offer cycle, nothing is taken
  assign instrUnknown = instrReady && instrValid && !known;

  // Observation port, registered one edge after its address
  assign dbgData = s_reg.dbgData;
endmodule

`default_nettype wire

// ---- dmtd_consts.svh ----
// Constants of the data memory transfer decoder
`ifndef DMTD_CONSTS_SVH
`define DMTD_CONSTS_SVH

// Instruction field positions
`define DMTD_OPC_MSB 15
`define DMTD_OPC_LSB 11
`define DMTD_ROW_MSB 10
`define DMTD_ROW_LSB 8
`define DMTD_COL_MSB 7
`define DMTD_COL_LSB 4
`define DMTD_LOW_MSB 3
`define DMTD_LOW_LSB 0

// Opcodes
`define DMTD_OPC_STORE 5'h18
`define DMTD_OPC_MOVE_TO_IND 5'h0A
`define DMTD_OPC_MOVE_FROM_IND 5'h1A
`define DMTD_OPC_MOVE_IMM 5'h1D
`define DMTD_OPC_LOAD 5'h08

// Address layout: bank, row, column
`define DMTD_BANK_W 4
`define DMTD_ROW_W 3
`define DMTD_COL_W 4
`define DMTD_ADDR_W 11
`define DMTD_MEM_WORDS 2048

// Reset values
`define DMTD_RST_WORD 16'h0000
`define DMTD_RST_ADDR 11'h000
`define DMTD_RST_NIB 4'h0

`endif

// ---- dmtd_pkg.sv ----
// Types of the data memory transfer decoder
`default_nettype none
package dmtd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_GETREG,
    ST_GETSRC,
    ST_STORE
  } dmtd_state_t;

  typedef struct packed {
    dmtd_state_t st;
    logic [15:0] word;
    logic [3:0] data;
    logic [3:0] col;
    logic [3:0] dbgData;
  } dmtd_regs_t;

endpackage

`default_nettype wire

// ---- dmtd_addr_if.sv ----
// Interface between the sequencer and the address former
`timescale 1ns/100ps
`default_nettype none
`include "dmtd_consts.svh"

interface dmtd_addr_if;
  logic [15:0] word;
  logic [`DMTD_BANK_W-1:0] bank;
  logic idxEn;
  logic [`DMTD_ADDR_W-1:0] idx;
  logic ptrEn;
  logic [`DMTD_BANK_W+`DMTD_ROW_W-1:0] rowPtr;
  logic [`DMTD_BANK_W+`DMTD_ROW_W-1:0] regPtr;
  logic [3:0] grVal;
  logic [`DMTD_ADDR_W-1:0] dirAddr;
  logic [`DMTD_ADDR_W-1:0] regAddr;
  logic [`DMTD_ADDR_W-1:0] indAddr;

  modport former(input word, bank, idxEn, idx, ptrEn, rowPtr, regPtr, grVal,
    output dirAddr, regAddr, indAddr);
  modport user(output word, bank, idxEn, idx, ptrEn, rowPtr, regPtr, grVal,
    input dirAddr, regAddr, indAddr);
endinterface

`default_nettype wire

// ---- dmtd_addr_form.sv ----
// Address former: direct, general register and indirect addresses
`timescale 1ns/100ps
`default_nettype none
`include "dmtd_consts.svh"

module dmtd_addr_form (
  dmtd_addr_if.former af
);
  logic [`DMTD_ROW_W-1:0] rowField;
  logic [`DMTD_COL_W-1:0] colField;
  logic [`DMTD_COL_W-1:0] regField;

  // Operand fields
  assign rowField = af.word[`DMTD_ROW_MSB:`DMTD_ROW_LSB];
  assign colField = af.word[`DMTD_COL_MSB:`DMTD_COL_LSB];
  assign regField = af.word[`DMTD_LOW_MSB:`DMTD_LOW_LSB];

  // Direct address, optionally ORed with the index register
  always_comb begin
    af.dirAddr = {af.bank, rowField, colField};
    if (af.idxEn) begin
      af.dirAddr = af.dirAddr | af.idx;
    end
  end

  // General register sits in the row named by the register pointer
  assign af.regAddr = {af.regPtr, regField};

  // Indirect address: column from the general register value
  always_comb begin
    if (af.ptrEn) begin
      af.indAddr = {af.rowPtr, af.grVal};
    end else begin
      af.indAddr = {af.bank, rowField, af.grVal};
    end
  end
endmodule

`default_nettype wire

// ---- dmtd_core_sva.sv ----
// Checker of the decoder handshake timing
`timescale 1ns/100ps
`default_nettype none
module dmtd_core_sva (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic instrValid,
  input wire logic instrReady,
  input wire logic [15:0] instrWord,
  input wire logic instrDone,
  input wire logic instrUnknown
);
  // Offer seen while idle
  logic acc;
  logic [4:0] opc;
  assign opc = instrWord[15:11];
  assign acc = instrValid && instrReady;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_imm; acc && opc == 5'h1D |=> instrDone; endproperty
  a_imm: assert property (p_imm) else $error("late imm");
  property p_st; acc && opc == 5'h18 |=> !instrDone ##1 instrDone; endproperty
  a_st: assert property (p_st) else $error("late store");
  property p_ld; acc && opc == 5'h08 |=> !instrDone ##1 instrDone; endproperty
  a_ld: assert property (p_ld) else $error("late load");
  property p_to; acc && opc == 5'h0A |=> !instrDone [*2] ##1 instrDone; endproperty
  a_to: assert property (p_to) else $error("late move");
  property p_fr; acc && opc == 5'h1A |=> !instrDone [*2] ##1 instrDone; endproperty
  a_fr: assert property (p_fr) else $error("late move");
  property p_unk; acc && !(opc inside {5'h1D, 5'h18, 5'h08, 5'h0A, 5'h1A})
    |-> instrUnknown ##1 instrReady; endproperty
  a_unk: assert property (p_unk) else $error("bad refuse");
  property p_bsy; acc && opc == 5'h18 |=> !instrReady [*2] ##1 instrReady; endproperty
  a_bsy: assert property (p_bsy) else $error("bad busy");
  property p_dn; instrDone |-> !instrReady ##1 instrReady; endproperty
  a_dn: assert property (p_dn) else $error("bad done");
endmodule
bind dmtd_core dmtd_core_sva i_dmtd_core_sva (.clk_sys, .reset_n, .instrValid,
  .instrReady, .instrWord, .instrDone, .instrUnknown);
`default_nettype wire

// ---- data_memory_transfer_decode_test.sv ----
// Self-checking bench of the decoder
`timescale 1ns/100ps
`default_nettype none
module data_memory_transfer_decode_test;
  logic clk_sys, reset_n, instrValid, instrReady, instrDone, instrUnknown;
  logic pointerEnableFlag, indexEnableFlag;
  logic [15:0] instrWord;
  logic [3:0] bankSel, dbgData;
  logic [6:0] rowPointer, registerPointer;
  logic [10:0] indexRegister, dbgAddr;
  logic [3:0] m [2048];
  logic [4:0] ops [6] = '{5'h1D, 5'h18, 5'h08, 5'h0A, 5'h1A, 5'h15};
  logic [31:0] seed = 32'h0001_293D;
  logic [31:0] x;
  int fails = 0;
  int nCompared = 0;
  int k;
  dmtd_core i_dmtd_core (.clk_sys, .reset_n, .instrValid, .instrReady, .instrWord,
    .instrDone, .instrUnknown, .bankSel, .pointerEnableFlag, .rowPointer,
    .indexEnableFlag, .indexRegister, .registerPointer, .dbgAddr, .dbgData);
  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Compare and count
  task automatic chk(input logic [3:0] s, input logic [3:0] e);
    nCompared++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Verdict
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One instruction against the model
  task automatic run(input logic [15:0] w);
    logic [10:0] d, r, i, a;
    logic [3:0] v;
    logic [1:0] n;
    int t;
    d = {bankSel, w[10:4]} | (indexEnableFlag ? indexRegister : 11'h000);
    r = {registerPointer, w[3:0]};
    i = {pointerEnableFlag ? rowPointer : {bankSel, w[10:8]}, m[r]};
    n = 2'h0;
    case (w[15:11])
      5'h1D: {a, v, n} = {d, w[3:0], 2'h1};
      5'h18: {a, v, n} = {d, m[r], 2'h2};
      5'h08: {a, v, n} = {r, m[d], 2'h2};
      5'h0A: {a, v, n} = {i, m[d], 2'h3};
      5'h1A: {a, v, n} = {d, m[i], 2'h3};
      default: a = d;
    endcase
    for (t = 0; t < 20 && instrReady !== 1'h1; t++) @(posedge clk_sys) #1;
    if (t == 20) begin
      fails++;
      end_sim();
    end
    instrWord = w;
    instrValid = 1'h1;
    #1 chk(4'(instrUnknown), 4'(n == 2'h0));
    @(posedge clk_sys) #1;
    instrValid = 1'h0;
    if (n == 2'h0) begin
      chk(4'(instrReady), 4'h1);
      @(posedge clk_sys) #1;
    end else begin
      for (t = 1; t < 8 && instrDone !== 1'h1; t++) @(posedge clk_sys) #1;
      chk(4'(t), 4'(n));
      if (t == 8) end_sim();
      m[a] = v;
      dbgAddr = a;
      repeat (2) @(posedge clk_sys);
      #1 chk(dbgData, v);
      dbgAddr = r;
      @(posedge clk_sys) #1;
      chk(dbgData, m[r]);
    end
  endtask
  // Clock
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Reset, fill all memory, then random traffic
  initial begin
    {reset_n, instrValid, instrWord, bankSel, pointerEnableFlag, indexEnableFlag} = '0;
    {rowPointer, registerPointer, indexRegister, dbgAddr} = '0;
    repeat (5) @(posedge clk_sys);
    #1 reset_n = 1'h1;
    for (k = 0; k < 2048; k++) begin
      x = rnd();
      bankSel = k[10:7];
      run({5'h1D, k[6:0], x[3:0]});
    end
    $display("fill test ended");
    for (k = 0; k < 400; k++) begin
      x = rnd();
      {pointerEnableFlag, indexEnableFlag, bankSel, rowPointer, registerPointer} = x[19:0];
      indexRegister = x[30:20];
      x = rnd();
      run({ops[x[31:29] % 6], x[10:0]});
    end
    $display("random test ended");
    end_sim();
  end
endmodule
`default_nettype wire
